// ### rtl/ascfg_pkg.sv
package ascfg_pkg;
  // register byte offsets
  localparam logic [7:0] OFS_TIME_HIGH = 8'h0C;
  localparam logic [7:0] OFS_TIME_LOW = 8'h10;
  localparam logic [7:0] OFS_WD_LOW = 8'h28;
  localparam logic [7:0] OFS_SEQ_UPPER = 8'h2C;
  // writable bits of each register; the rest read as zero
  localparam logic [31:0] MASK_TIME_HIGH = 32'h00FC_0000;
  localparam logic [31:0] MASK_TIME_LOW = 32'h3FFF_FFFF;
  localparam logic [31:0] MASK_WD_LOW = 32'h0000_0FFF;
  localparam logic [31:0] MASK_SEQ_UPPER = 32'h00FF_FFFF;
  localparam logic [31:0] RESET_VALUE = 32'h0000_0000;
  // field positions
  localparam int CODE_W = 3;
  localparam int CH16_LSB = 18;
  localparam int CH17_LSB = 21;
  localparam int WD_W = 12;
  localparam int CHAN_W = 5;
  localparam int LEN_LSB = 20;
  localparam int LEN_W = 4;
  localparam int FIRST_UPPER_SLOT = 12;
  localparam int LOW_CHANNELS = 10;
  // channel numbers with their own code outside the low register
  localparam logic [4:0] CHAN_16 = 5'h10;
  localparam logic [4:0] CHAN_17 = 5'h11;
  // sampling time in half converter cycles, so 1.5 becomes 3
  localparam int HALF_W = 9;
  localparam logic [8:0] HALF_0 = 9'h003;
  localparam logic [8:0] HALF_1 = 9'h00F;
  localparam logic [8:0] HALF_2 = 9'h01B;
  localparam logic [8:0] HALF_3 = 9'h039;
  localparam logic [8:0] HALF_4 = 9'h053;
  localparam logic [8:0] HALF_5 = 9'h06F;
  localparam logic [8:0] HALF_6 = 9'h08F;
  localparam logic [8:0] HALF_7 = 9'h1DF;
endpackage : ascfg_pkg

// ### rtl/ascfg_time_lut.sv
`timescale 1ns/1ns
`default_nettype none
module ascfg_time_lut
  import ascfg_pkg::*;
(
  input wire logic [ascfg_pkg::CODE_W-1:0] code, // sampling-time code
  output logic [ascfg_pkg::HALF_W-1:0] half_cycles // duration in half cycles
);
  ////////////////////////////////////////////////////////////////////////////
  // code to duration, pure decode
  always_comb begin
    case (code)
      3'h0: half_cycles = HALF_0;
      3'h1: half_cycles = HALF_1;
      3'h2: half_cycles = HALF_2;
      3'h3: half_cycles = HALF_3;
      3'h4: half_cycles = HALF_4;
      3'h5: half_cycles = HALF_5;
      3'h6: half_cycles = HALF_6;
      default: half_cycles = HALF_7;
    endcase
  end
endmodule : ascfg_time_lut
`default_nettype wire

// ### rtl/ascfg_top.sv
// Local design decision: the strobed register port.
`timescale 1ns/1ns
`default_nettype none
module ascfg_top
  import ascfg_pkg::*;
(
  input wire logic sys_clk, // 10 MHz register clock
  input wire logic rst_b, // async reset, active low
  input wire logic [7:0] addr, // register byte address
  input wire logic [31:0] wr_data, // write data
  input wire logic wr_stb, // one-cycle write strobe
  input wire logic rd_stb, // one-cycle read strobe
  output logic [31:0] rd_data, // read data, cycle after rd_stb
  input wire logic sample_req, // sequencer asks for a channel's time
  input wire logic [ascfg_pkg::CHAN_W-1:0] sample_chan, // channel being sampled
  output logic [ascfg_pkg::CODE_W-1:0] sample_code, // its time code
  output logic [ascfg_pkg::HALF_W-1:0] sample_half, // its time in half cycles
  input wire logic slot_restart, // start sequence from slot 0
  input wire logic slot_step, // advance to next slot
  output logic [ascfg_pkg::LEN_W-1:0] slot_idx, // current slot
  output logic slot_last, // current slot is the final one
  output logic [ascfg_pkg::CHAN_W-1:0] slot_upper_chan, // channel of slot 12..15, else 0
  output logic [ascfg_pkg::LEN_W:0] seq_length, // conversions in sequence, 1..16
  input wire logic conv_valid, // a conversion result is ready
  input wire logic [ascfg_pkg::WD_W-1:0] conv_data, // that result
  output logic wd_below // result fell under the low limit, one cycle
);
  ////////////////////////////////////////////////////////////////////////////
  // register store
  logic [31:0] time_high;
  logic [31:0] time_low;
  logic [31:0] wd_low;
  logic [31:0] seq_upper;
  wire hit_high = addr == OFS_TIME_HIGH;
  wire hit_low = addr == OFS_TIME_LOW;
  wire hit_wd = addr == OFS_WD_LOW;
  wire hit_seq = addr == OFS_SEQ_UPPER;
  // masking keeps reserved bits at zero even if software breaks the habit
  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      time_high <= RESET_VALUE;
      time_low <= RESET_VALUE;
      wd_low <= RESET_VALUE;
      seq_upper <= RESET_VALUE;
    end else if (wr_stb) begin
      if (hit_high) time_high <= wr_data & MASK_TIME_HIGH;
      if (hit_low) time_low <= wr_data & MASK_TIME_LOW;
      if (hit_wd) wd_low <= wr_data & MASK_WD_LOW; // whole word only
      if (hit_seq) seq_upper <= wr_data & MASK_SEQ_UPPER;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // read path, unmapped addresses answer zero
  wire [31:0] next_rd_data = !rd_stb ? RESET_VALUE :
    hit_high ? time_high : hit_low ? time_low : hit_wd ? wd_low : hit_seq ? seq_upper : RESET_VALUE;
  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) rd_data <= RESET_VALUE;
    else rd_data <= next_rd_data;
  end

  ////////////////////////////////////////////////////////////////////////////
  // channel to code; invalid channels fall back to the shortest time
  function automatic logic [CODE_W-1:0] chan_code(input logic [CHAN_W-1:0] ch, input logic [31:0] lo,
                                                   input logic [31:0] hi);
    logic [CODE_W-1:0] r;
    r = '0;
    for (int n = 0; n < LOW_CHANNELS; n++) begin
      if (ch == CHAN_W'(n)) r = lo[n*CODE_W +: CODE_W];
    end
    if (ch == CHAN_16) r = hi[CH16_LSB +: CODE_W];
    if (ch == CHAN_17) r = hi[CH17_LSB +: CODE_W];
    return r;
  endfunction : chan_code

  wire [CODE_W-1:0] req_code = chan_code(sample_chan, time_low, time_high);
  wire [HALF_W-1:0] req_half;
  ascfg_time_lut u_lut (
    .code(req_code),
    .half_cycles(req_half)
  );
  // hold the answer until the next request so the sequencer can count against it
  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      sample_code <= '0;
      sample_half <= HALF_0;
    end else if (sample_req) begin
      sample_code <= req_code;
      sample_half <= req_half;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // slot walk over the programmed length
  wire [LEN_W-1:0] count_minus_one = seq_upper[LEN_LSB +: LEN_W];
  wire at_end = slot_idx == count_minus_one;
  wire [LEN_W-1:0] next_slot_idx = slot_restart ? '0 : !slot_step ? slot_idx :
    at_end ? '0 : LEN_W'(slot_idx + 1'b1);
  wire upper = 32'(next_slot_idx) >= FIRST_UPPER_SLOT;
  wire [1:0] upper_sel = next_slot_idx[1:0];
  wire [CHAN_W-1:0] next_upper_chan = upper ? seq_upper[upper_sel*CHAN_W +: CHAN_W] : '0;
  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      slot_idx <= '0;
      slot_last <= 1'b1;
      slot_upper_chan <= '0;
      seq_length <= 5'h01;
    end else begin
      slot_idx <= next_slot_idx;
      slot_last <= next_slot_idx == count_minus_one;
      slot_upper_chan <= next_upper_chan;
      seq_length <= {1'b0, count_minus_one} + 5'h01;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // watchdog floor compare
  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) wd_below <= 1'b0;
    else wd_below <= conv_valid && (conv_data < wd_low[WD_W-1:0]);
  end

  ////////////////////////////////////////////////////////////////////////////
  // checks
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!rst_b);

  sequence wd_write_s;
    wr_stb && hit_wd;
  endsequence
  sequence wd_read_s;
    rd_stb && hit_wd;
  endsequence
  // one sampling request, and separately one plain slot step
  sequence req_s;
    sample_req;
  endsequence
  sequence step_s;
    slot_step && !slot_restart;
  endsequence

  wd_readback_a: assert property (wd_write_s ##1 wd_read_s |=> rd_data == {20'h0_0000, $past(wr_data[11:0], 2)})
    else $error("watchdog limit readback wrong");
  high_reserved_a: assert property (rd_stb && hit_high |=> (rd_data & ~MASK_TIME_HIGH) == 32'h0000_0000)
    else $error("reserved bits of high time register not zero");
  longest_time_a: assert property ($past(sample_req) && sample_code == 3'h7 |-> sample_half == HALF_7)
    else $error("longest sampling time wrong");
  ch9_code_a: assert property (sample_req && sample_chan == 5'h09 |=> sample_code == $past(time_low[29:27]))
    else $error("channel 9 code wrong");
  length_a: assert property (wr_stb && hit_seq |=> ##1 seq_length == {1'b0, $past(wr_data[23:20], 2)} + 5'h01)
    else $error("sequence length wrong");
  slot15_a: assert property (wr_stb && hit_seq |=> seq_upper[19:15] == $past(wr_data[19:15]))
    else $error("slot 15 channel not stored");
  bad_chan_a: assert property (sample_req && sample_chan == 5'h0A |=> sample_code == 3'h0)
    else $error("invalid channel gave a code");
  slot_wrap_a: assert property (slot_step && !slot_restart && at_end |=> slot_idx == 4'h0)
    else $error("slot walk did not wrap at length");
  wd_below_a: assert property (conv_valid && conv_data < wd_low[11:0] |=> wd_below)
    else $error("watchdog floor missed");

  // read data stands for one cycle only, so an idle bus must read back zero
  rd_idle_a: assert property (!rd_stb |=> rd_data == RESET_VALUE)
    else $error("read data outside a read cycle");
  // reserved bits of every mapped register must read as zero
  low_reserved_a: assert property (rd_stb && hit_low |=> rd_data[31:30] == 2'h0)
    else $error("reserved bits of low time register not zero");
  wd_reserved_a: assert property (rd_stb && hit_wd |=> rd_data[31:12] == 20'h0_0000)
    else $error("reserved bits of watchdog limit not zero");
  seq_reserved_a: assert property (rd_stb && hit_seq |=> rd_data[31:24] == 8'h00)
    else $error("reserved bits of sequence register not zero");
  // stores land in the cycle after the strobe
  low_store_a: assert property (wr_stb && hit_low |=> time_low[29:0] == $past(wr_data[29:0]))
    else $error("low time register not stored");
  wd_store_a: assert property (wr_stb && hit_wd |=> wd_low[11:0] == $past(wr_data[11:0]))
    else $error("watchdog limit not stored");
  slot14_a: assert property (wr_stb && hit_seq |=> seq_upper[14:10] == $past(wr_data[14:10]))
    else $error("slot 14 channel not stored");

  // the code handed out must come from the field of the requested channel
  ch0_code_a: assert property (req_s and sample_chan == 5'h00 |=> sample_code == $past(time_low[2:0]))
    else $error("channel 0 code wrong");
  ch16_code_a: assert property (req_s and sample_chan == CHAN_16 |=> sample_code == $past(time_high[20:18]))
    else $error("channel 16 code wrong");
  ch17_code_a: assert property (req_s and sample_chan == CHAN_17 |=> sample_code == $past(time_high[23:21]))
    else $error("channel 17 code wrong");
  gap_chan_a: assert property (req_s and sample_chan == 5'h12 |=> sample_code == 3'h0)
    else $error("channel above 17 gave a code");
  shortest_time_a: assert property ($past(sample_req) && sample_code == 3'h0 |-> sample_half == HALF_0)
    else $error("shortest sampling time wrong");
  // the sequencer counts against a held answer, so it must not drift
  code_hold_a: assert property (!sample_req |=> $stable(sample_code) && $stable(sample_half))
    else $error("sampling answer changed without a request");

  // slot walk: restart, plain step, and the quiet lower slots
  restart_a: assert property (slot_restart |=> slot_idx == 4'h0)
    else $error("restart did not return to slot 0");
  step_a: assert property (step_s and !at_end |=> slot_idx == LEN_W'($past(slot_idx) + 1'b1))
    else $error("slot step did not advance by one");
  lower_quiet_a: assert property (32'(slot_idx) < FIRST_UPPER_SLOT |-> slot_upper_chan == 5'h00)
    else $error("lower slot showed an upper channel");
  // the floor flag is a one-cycle pulse per result
  wd_quiet_a: assert property (!conv_valid |=> !wd_below)
    else $error("watchdog flag without a result");
endmodule : ascfg_top
`default_nettype wire

// ### tb/ascfg_tb_top.sv
`timescale 1ns/1ns
`default_nettype none
module ascfg_top_tb_top;
  import ascfg_pkg::*;
  logic sys_clk = 1'b0, rst_b = 1'b0, wr_stb = 1'b0, rd_stb = 1'b0, sample_req = 1'b0;
  logic slot_restart = 1'b0, slot_step = 1'b0, conv_valid = 1'b0, slot_last, wd_below;
  logic [7:0] addr = 8'h00;
  logic [31:0] wr_data = 32'h0000_0000, rd_data, v;
  logic [4:0] sample_chan = 5'h00, slot_upper_chan, seq_length;
  logic [2:0] sample_code;
  logic [8:0] sample_half;
  logic [3:0] slot_idx;
  logic [11:0] conv_data = 12'h000;
  int failures = 0, checked = 0;
  // sampling times doubled so the half cycle stays integer
  localparam logic [8:0] HALF_TAB [8] = '{9'h003, 9'h00F, 9'h01B, 9'h039, 9'h053, 9'h06F, 9'h08F, 9'h1DF};
  localparam logic [4:0] CHS [12] = '{0, 1, 2, 3, 4, 5, 6, 7, 8, 9, 16, 17};
  localparam logic [7:0] OFS [4] = '{8'h0C, 8'h10, 8'h28, 8'h2C};
  localparam logic [11:0] WD_IN [3] = '{12'h7FF, 12'h800, 12'h000};
  ascfg_top uut (.sys_clk(sys_clk), .rst_b(rst_b), .addr(addr), .wr_data(wr_data), .wr_stb(wr_stb),
    .rd_stb(rd_stb), .rd_data(rd_data), .sample_req(sample_req), .sample_chan(sample_chan),
    .sample_code(sample_code), .sample_half(sample_half), .slot_restart(slot_restart), .slot_step(slot_step),
    .slot_idx(slot_idx), .slot_last(slot_last), .slot_upper_chan(slot_upper_chan), .seq_length(seq_length),
    .conv_valid(conv_valid), .conv_data(conv_data), .wd_below(wd_below));
  initial begin
    forever #50 sys_clk = ~sys_clk;
  end
  ////////////////////////////////////////////////////////////////////////////////
  task automatic final_report;
    if (failures == 0 && checked > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask : final_report
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checked++;
    if (got !== exp) begin
      failures++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk
  // bus cycles: strobe one cycle, read data looked at in the following cycle only
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge sys_clk) begin addr <= a; wr_data <= d; wr_stb <= 1'b1; end
    @(posedge sys_clk) wr_stb <= 1'b0;
  endtask : wr
  task automatic rd(input logic [7:0] a, input logic [31:0] exp);
    @(posedge sys_clk) begin addr <= a; rd_stb <= 1'b1; end
    @(posedge sys_clk) rd_stb <= 1'b0;
    #1 chk(rd_data, exp);
  endtask : rd
  task automatic req(input logic [4:0] c);
    @(posedge sys_clk) begin sample_req <= 1'b1; sample_chan <= c; end
    @(posedge sys_clk) sample_req <= 1'b0;
    #1;
  endtask : req
  task automatic walk(input logic rs, input logic st);
    @(posedge sys_clk) begin slot_restart <= rs; slot_step <= st; end
    @(posedge sys_clk) begin slot_restart <= 1'b0; slot_step <= 1'b0; end
    #1;
  endtask : walk
  ////////////////////////////////////////////////////////////////////////////////
  // registers: reset zero, every writable bit stored, idle read zero, unmapped place ignored
  task automatic t_regs;
    foreach (OFS[i]) rd(OFS[i], 32'h0000_0000);
    wr(8'h0C, 32'h00FC_0000);
    rd(8'h0C, 32'h00FC_0000);
    wr(8'h10, 32'h3FFF_FFFF);
    rd(8'h10, 32'h3FFF_FFFF);
    wr(8'h28, 32'h0000_0FFF);
    rd(8'h28, 32'h0000_0FFF);
    @(posedge sys_clk) #1 chk(rd_data, 32'h0000_0000);
    wr(8'h2C, 32'h00FF_FFFF);
    rd(8'h2C, 32'h00FF_FFFF);
    wr(8'h14, 32'h1234_5678);
    rd(8'h14, 32'h0000_0000);
    rd(8'h28, 32'h0000_0FFF);
  endtask : t_regs
  // every code on every channel, each channel its own code
  task automatic t_codes;
    logic [2:0] e;
    for (int k = 0; k < 8; k++) begin
      v = 32'h0000_0000;
      for (int n = 0; n < 10; n++) v[3*n+:3] = 3'((k + n) % 8);
      wr(8'h10, v);
      wr(8'h0C, {8'h00, 3'((k + 11) % 8), 3'((k + 10) % 8), 18'h0_0000});
      for (int j = 0; j < 12; j++) begin
        req(CHS[j]);
        e = 3'((k + j) % 8);
        chk(32'(sample_code), 32'(e));
        chk(32'(sample_half), 32'(HALF_TAB[e]));
      end
    end
    req(5'h0A);
    chk(32'(sample_code), 32'h0000_0000);
  endtask : t_codes
  // full sixteen-slot walk with upper slot channels, then a two-slot one
  task automatic t_slots;
    wr(8'h2C, {8'h00, 4'hF, 5'h03, 5'h09, 5'h10, 5'h11});
    repeat (2) @(posedge sys_clk);
    #1 chk(32'(seq_length), 32'h0000_0010);
    walk(1'b1, 1'b1);
    chk(32'(slot_idx), 32'h0000_0000);
    for (int i = 1; i <= 16; i++) begin
      walk(1'b0, 1'b1);
      chk(32'(slot_idx), 32'(i % 16));
      chk(32'(slot_last), 32'(i == 15));
      v = (i == 12) ? 32'h11 : (i == 13) ? 32'h10 : (i == 14) ? 32'h09 : (i == 15) ? 32'h03 : 32'h0;
      chk(32'(slot_upper_chan), v);
    end
    wr(8'h2C, 32'h0010_0000);
    repeat (2) @(posedge sys_clk);
    #1 chk(32'(seq_length), 32'h0000_0002);
    walk(1'b1, 1'b0);
    walk(1'b0, 1'b1);
    chk(32'({slot_idx, slot_last}), 32'h0000_0003);
    walk(1'b0, 1'b1);
    chk(32'({slot_idx, slot_last}), 32'h0000_0000);
  endtask : t_slots
  // watchdog floor: one below the limit trips, the limit itself does not
  task automatic t_wd;
    wr(8'h28, 32'h0000_0800);
    foreach (WD_IN[i]) begin
      @(posedge sys_clk) begin conv_valid <= 1'b1; conv_data <= WD_IN[i]; end
      @(posedge sys_clk) conv_valid <= 1'b0;
      #1 chk(32'(wd_below), 32'(i != 1));
      @(posedge sys_clk) #1 chk(32'(wd_below), 32'h0000_0000);
    end
  endtask : t_wd
  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    #500000;
    failures++;
    final_report();
  end
  initial begin
    repeat (6) @(posedge sys_clk);
    rst_b <= 1'b1;
    #1 chk(32'({sample_half, slot_last, seq_length}), 32'h0000_00E1);
    t_regs();
    t_codes();
    t_slots();
    t_wd();
    final_report();
  end
endmodule : ascfg_top_tb_top
`default_nettype wire
